// ### core/wwd_pkg.sv
package wwd_pkg;

  // ****************************************
  // Register map, byte addresses.
  // ****************************************
  localparam logic [7:0] ADR_MODE   = 8'h00;
  localparam logic [7:0] ADR_TC     = 8'h04;
  localparam logic [7:0] ADR_FEED   = 8'h08;
  localparam logic [7:0] ADR_COUNT  = 8'h0C;
  localparam logic [7:0] ADR_WARN   = 8'h10;
  localparam logic [7:0] ADR_WINDOW = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_CLEAR  = 8'h1C;
  localparam logic [7:0] ADR_IRQEN  = 8'h20;

  // ****************************************
  // Fields, reset values and timing.
  // ****************************************
  localparam int          CNT_W        = 24;
  localparam int          ST_W         = 4;
  localparam int          ST_TIMEOUT   = 0;
  localparam int          ST_WARN      = 1;
  localparam int          ST_FEED_ERR  = 2;
  localparam int          ST_WD_RESET  = 3;
  localparam logic [23:0] TC_MIN       = 24'h0000FF;
  localparam logic [23:0] TC_RESET     = 24'h0000FF;
  localparam logic [23:0] WARN_RESET   = 24'h000000;
  localparam logic [23:0] WINDOW_RESET = 24'hFFFFFF;
  localparam logic [7:0]  FEED_KEY1    = 8'hAA;
  localparam logic [7:0]  FEED_KEY2    = 8'h55;
  localparam logic [1:0]  PRE_LAST     = 2'h3;

  // ****************************************
  // Types.
  // ****************************************
  typedef struct packed {
    logic window_en;
    logic sleep_run;
    logic feed_err_en;
    logic protect;
    logic reset_mode;
    logic enable;
  } wwd_mode_t;

  localparam wwd_mode_t MODE_RESET = '0;

  typedef enum logic [0:0] {
    FS_IDLE  = 1'b0,
    FS_ARMED = 1'b1
  } wwd_feed_state_t;

endpackage : wwd_pkg

// ### core/wwd_top.sv
// Overview of operation
// - Missed reload causes reset or interrupt.
// - Reset mode: expiry triggers chip reset.
// - Window mode: reload only inside allowed window.
// - Warning interrupt at programmable count point.
// - 24-bit counter behind fixed prescaler.
// - Time-out 256 counts minimum, steps of one count (four ticks).
// - Enable cannot be cleared by software.
// - Wrong feed gives immediate event if enabled.
// - Protected reload value writable after warning.
// - Flag records watchdog reset, stays readable.
// - Optionally keeps counting in deep sleep.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module wwd_top
  import wwd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        watchdog_tick_source_i,
  input  wire logic        deep_sleep_i,
  output logic             irq_o,
  output logic             chip_reset_o
);

  // ****************************************
  // State.
  // ****************************************
  wwd_mode_t        mode_q,   mode_d;
  logic [23:0]      tc_q,     tc_d;
  logic [23:0]      warn_q,   warn_d;
  logic [23:0]      win_q,    win_d;
  logic [23:0]      count_q,  count_d;
  logic [1:0]       pre_q,    pre_d;
  logic [ST_W-1:0]  status_q, status_d;
  logic [ST_W-1:0]  irqen_q,  irqen_d;
  wwd_feed_state_t  fs_q,     fs_d;
  logic             ack_q,    ack_d;
  logic [31:0]      rdat_q,   rdat_d;
  logic             wdr_q,    wdr_d;

  logic        acc;
  logic        wr;
  logic [31:0] wdat;
  logic        run;
  logic        ptick;
  logic        expire;
  logic        seq_ok;
  logic        seq_bad;
  logic        early;
  logic        good_feed;
  logic        bad_feed;
  logic        evt;
  logic        tc_wr_ok;
  logic        warn_hit;

  // Byte-lane merge used by every writable register.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // Bus decode and event detection.
  // ****************************************
  // The access completes at the edge where ack is high, so writes land there.
  assign acc  = wb_cyc_i && wb_stb_i && ack_q;
  assign wr   = acc && wb_we_i;
  assign wdat = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // Counting pauses in deep sleep unless software asked otherwise.
  assign run    = mode_q.enable && (!deep_sleep_i || mode_q.sleep_run);
  assign ptick  = run && watchdog_tick_source_i && (pre_q == PRE_LAST);
  assign expire = ptick && (count_q == '0);

  // Any completed access after the first key must be the second key.
  always_comb
  begin
    fs_d    = fs_q;
    seq_ok  = 1'b0;
    seq_bad = 1'b0;
    case (fs_q)
      FS_IDLE:
      begin
        if (wr && wb_adr_i == ADR_FEED)
        begin
          fs_d    = (wdat[7:0] == FEED_KEY1) ? FS_ARMED : FS_IDLE;
          seq_bad = (wdat[7:0] != FEED_KEY1);
        end
      end
      FS_ARMED:
      begin
        if (acc)
        begin
          fs_d    = FS_IDLE;
          seq_ok  = wr && wb_adr_i == ADR_FEED && wdat[7:0] == FEED_KEY2;
          seq_bad = !seq_ok;
        end
      end
      default:
      begin
        fs_d = FS_IDLE;
      end
    endcase
  end

  assign early     = mode_q.window_en && (count_q > win_q);
  assign good_feed = mode_q.enable && seq_ok && !early;
  assign bad_feed  = mode_q.enable && (seq_bad || (seq_ok && early));
  assign evt       = expire || (bad_feed && mode_q.feed_err_en);
  assign tc_wr_ok  = !mode_q.protect || (count_q <= warn_q);
  assign warn_hit  = ptick && (count_q != '0) && ((count_q - 24'h000001) == warn_q);

  // ****************************************
  // Next-state logic.
  // ****************************************
  always_comb
  begin
    mode_d   = mode_q;
    tc_d     = tc_q;
    warn_d   = warn_q;
    win_d    = win_q;
    count_d  = count_q;
    pre_d    = pre_q;
    status_d = status_q;
    irqen_d  = irqen_q;
    wdr_d    = 1'b0;
    ack_d    = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d   = rdat_q;
    if (ack_d)
    begin
      case (wb_adr_i)
        ADR_MODE:   rdat_d = {26'h0, mode_q};
        ADR_TC:     rdat_d = {8'h00, tc_q};
        ADR_COUNT:  rdat_d = {8'h00, count_q};
        ADR_WARN:   rdat_d = {8'h00, warn_q};
        ADR_WINDOW: rdat_d = {8'h00, win_q};
        ADR_STATUS: rdat_d = {28'h0, status_q};
        ADR_IRQEN:  rdat_d = {28'h0, irqen_q};
        default:    rdat_d = 32'h0000_0000;
      endcase
    end
    if (run && watchdog_tick_source_i)
    begin
      pre_d = pre_q + 2'h1;
    end
    if (ptick)
    begin
      count_d = expire ? tc_q : count_q - 24'h000001;
    end
    if (wr)
    begin
      case (wb_adr_i)
        ADR_MODE:
        begin
          mode_d        = wwd_mode_t'(6'(merge({26'h0, mode_q}, wb_dat_i, wb_sel_i)));
          mode_d.enable = mode_q.enable | mode_d.enable;
          if (!mode_q.enable && mode_d.enable)
          begin
            count_d = tc_q;
            pre_d   = 2'h0;
          end
        end
        ADR_TC:
        begin
          if (tc_wr_ok)
          begin
            tc_d = 24'(merge({8'h00, tc_q}, wb_dat_i, wb_sel_i));
            tc_d = (tc_d < TC_MIN) ? TC_MIN : tc_d;
          end
        end
        ADR_WARN:   warn_d  = 24'(merge({8'h00, warn_q}, wb_dat_i, wb_sel_i));
        ADR_WINDOW: win_d   = 24'(merge({8'h00, win_q}, wb_dat_i, wb_sel_i));
        ADR_CLEAR:  status_d = status_q & ~wdat[ST_W-1:0];
        ADR_IRQEN:  irqen_d = wdat[ST_W-1:0];
        default:    ;
      endcase
    end
    // Hardware sets are applied after software clears so that a set wins.
    if (good_feed)
    begin
      count_d = tc_q;
      pre_d   = 2'h0;
    end
    if (warn_hit)
    begin
      status_d[ST_WARN] = 1'b1;
    end
    if (bad_feed)
    begin
      status_d[ST_FEED_ERR] = 1'b1;
    end
    if (evt)
    begin
      status_d[ST_TIMEOUT] = 1'b1;
      count_d              = tc_q;
      pre_d                = 2'h0;
      if (mode_q.reset_mode)
      begin
        // The chip reset returns the block to its reset setup, all but the flag and the counter, which reloads the old tc_q.
        wdr_d                 = 1'b1;
        status_d              = '0;
        status_d[ST_WD_RESET] = 1'b1;
        mode_d                = MODE_RESET;
        tc_d                  = TC_RESET;
        warn_d                = WARN_RESET;
        win_d                 = WINDOW_RESET;
        irqen_d               = '0;
      end
    end
  end

  // ****************************************
  // Registers.
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q   <= MODE_RESET;
      tc_q     <= TC_RESET;
      warn_q   <= WARN_RESET;
      win_q    <= WINDOW_RESET;
      count_q  <= TC_RESET;
      pre_q    <= 2'h0;
      status_q <= '0;
      irqen_q  <= '0;
      fs_q     <= FS_IDLE;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
      wdr_q    <= 1'b0;
    end
    else
    begin
      mode_q   <= mode_d;
      tc_q     <= tc_d;
      warn_q   <= warn_d;
      win_q    <= win_d;
      count_q  <= count_d;
      pre_q    <= pre_d;
      status_q <= status_d;
      irqen_q  <= irqen_d;
      fs_q     <= fs_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      wdr_q    <= wdr_d;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign chip_reset_o = wdr_q;
  assign irq_o        = |(status_q & irqen_q);

  // ****************************************
  // Checks.
  // ****************************************
  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    mode_q.enable && !evt |=> mode_q.enable;
  endproperty
  a_lock: assert property (p_lock) else $error("Enable dropped without a watchdog reset.");
  property p_reset_out;
    @(posedge clk_i) disable iff (rst_i)
    evt && mode_q.reset_mode |=> chip_reset_o ##1 !chip_reset_o;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("Reset-mode event gave no one-cycle chip reset.");
  property p_flag;
    @(posedge clk_i) disable iff (rst_i)
    chip_reset_o |-> status_q[ST_WD_RESET] && !mode_q.enable;
  endproperty
  a_flag: assert property (p_flag) else $error("Chip reset without the reset flag.");
  // The cause of a counter step lies one edge back, so every exclusion is taken from there.
  property p_prescale;
    @(posedge clk_i) disable iff (rst_i)
    !$past(good_feed) && !$past(evt) && !$past(wr) && $changed(count_q)
    |-> $past(pre_q) == PRE_LAST && $past(watchdog_tick_source_i);
  endproperty
  a_prescale: assert property (p_prescale) else $error("Counter moved off a prescaled tick.");
  property p_tc_min;
    @(posedge clk_i) disable iff (rst_i)
    tc_q >= TC_MIN;
  endproperty
  a_tc_min: assert property (p_tc_min) else $error("Time-out below its minimum.");
  property p_bad_feed;
    @(posedge clk_i) disable iff (rst_i)
    bad_feed && mode_q.feed_err_en |=> chip_reset_o || status_q[ST_TIMEOUT];
  endproperty
  a_bad_feed: assert property (p_bad_feed) else $error("Wrong feed gave no immediate event.");
  property p_early;
    @(posedge clk_i) disable iff (rst_i)
    seq_ok && mode_q.enable && early && !evt
    |=> status_q[ST_FEED_ERR] && count_q == ($past(ptick) ? $past(count_q) - 24'h000001 : $past(count_q));
  endproperty
  a_early: assert property (p_early) else $error("Early feed was accepted.");
  property p_warn;
    @(posedge clk_i) disable iff (rst_i)
    warn_hit && !evt && !good_feed && !wr |=> status_q[ST_WARN] && count_q == warn_q;
  endproperty
  a_warn: assert property (p_warn) else $error("Warning point passed without flag.");
  property p_feed;
    @(posedge clk_i) disable iff (rst_i)
    good_feed && !evt && !(wr && wb_adr_i == ADR_TC) |=> count_q == $past(tc_q) && pre_q == 2'h0;
  endproperty
  a_feed: assert property (p_feed) else $error("Good feed did not reload the counter.");
  property p_protect;
    @(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == ADR_TC && mode_q.protect && count_q > warn_q && !evt |=> $stable(tc_q);
  endproperty
  a_protect: assert property (p_protect) else $error("Protected reload value changed early.");
  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
    deep_sleep_i && !mode_q.sleep_run && !good_feed && !wr && !evt |=> $stable(count_q);
  endproperty
  a_sleep: assert property (p_sleep) else $error("Counter ran in deep sleep.");
  property p_expire;
    @(posedge clk_i) disable iff (rst_i)
    expire && !mode_q.reset_mode |=> status_q[ST_TIMEOUT] && count_q == $past(tc_q);
  endproperty
  a_expire: assert property (p_expire) else $error("Expiry without time-out event.");

endmodule : wwd_top

// ### tb/windowed_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top;
  import wwd_pkg::*;

  // ****************************************
  // Signals.
  // ****************************************
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tick_q;
  logic        deep_sleep_i;
  logic        irq_o;
  logic        chip_reset_o;
  logic [31:0] rd;
  logic [31:0] a;
  int          error_cnt;
  int          checks;
  int          seed;
  int          tick_cnt;
  int          t0;
  int          n;
  int          exp_t;
  logic [23:0] tc;
  logic [7:0]  ra [5] = '{ADR_TC, ADR_WINDOW, ADR_WARN, ADR_STATUS, 8'h40};
  logic [31:0] rv [5] = '{32'h000000FF, 32'h00FFFFFF, 32'h0, 32'h0, 32'h0};

  // ****************************************
  // Clock, tick source and design.
  // ****************************************
  always #4 clk_i = ~clk_i;

  // Ticks every other cycle so the prescaler sees distinct pulses.
  always @(posedge clk_i)
  begin
    tick_q <= ~tick_q;
    if (tick_q) tick_cnt <= tick_cnt + 1;
  end

  wwd_top i_wwd_top (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_cyc_i               (wb_cyc_i),
    .wb_stb_i               (wb_stb_i),
    .wb_we_i                (wb_we_i),
    .wb_adr_i               (wb_adr_i),
    .wb_sel_i               (wb_sel_i),
    .wb_dat_i               (wb_dat_i),
    .wb_dat_o               (wb_dat_o),
    .wb_ack_o               (wb_ack_o),
    .watchdog_tick_source_i (tick_q),
    .deep_sleep_i           (deep_sleep_i),
    .irq_o                  (irq_o),
    .chip_reset_o           (chip_reset_o)
  );

  // ****************************************
  // Tasks.
  // ****************************************
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  // Ticks of the tick source from enabling to the time-out event.
  function automatic int timeout_ticks(input logic [23:0] t);
    return (int'(t) + 1) * (int'(PRE_LAST) + 1);
  endfunction : timeout_ticks

  // The answer time is never assumed; the wait ends on ack or at the 20-cycle bound.
  task xfer(input logic [7:0] ad, input logic we, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20)
    begin
      error_cnt++;
      end_of_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : xfer

  task do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  task wt(input logic w, input int lim);
    n = 0;
    while (!(w ? chip_reset_o === 1'b1 : irq_o === 1'b1) && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask : wt

  // ****************************************
  // Scenarios.
  // ****************************************
  initial
  begin
    clk_i = 1'b0; rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'hF; wb_dat_i = 32'h0; tick_q = 1'b0; deep_sleep_i = 1'b0;
    error_cnt = 0; checks = 0; seed = 97; tick_cnt = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      xfer(ra[i], 1'b0, 32'h0);
      chk("reset value", rv[i], rd);
    end
    xfer(ADR_TC, 1'b1, 32'h10);
    xfer(ADR_TC, 1'b0, 32'h0);
    chk("tc clamp", 32'h000000FF, rd);
    tc = 24'h000100 + (24'($random(seed)) & 24'h00003F);
    exp_t = timeout_ticks(tc);
    xfer(ADR_TC, 1'b1, {8'h00, tc});
    xfer(ADR_IRQEN, 1'b1, 32'h1);
    xfer(ADR_MODE, 1'b1, 32'h1);
    t0 = tick_cnt;
    xfer(ADR_MODE, 1'b1, 32'h0);
    xfer(ADR_MODE, 1'b0, 32'h0);
    chk1("enable kept", 1'b1, rd[0]);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    a = rd;
    repeat (20) @(posedge clk_i);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk1("count falls", 1'b1, rd < a);
    wt(1'b0, 20000);
    chk1("timeout ticks", 1'b1, (tick_cnt - t0 >= exp_t - 4) && (tick_cnt - t0 <= exp_t + 4));
    xfer(ADR_STATUS, 1'b0, 32'h0);
    chk1("timeout flag", 1'b1, rd[0]);
    xfer(ADR_IRQEN, 1'b1, 32'h0);
    #1 chk1("irq masked", 1'b0, irq_o);
    xfer(ADR_IRQEN, 1'b1, 32'h1);
    xfer(ADR_CLEAR, 1'b1, 32'hF);
    #1 chk1("irq cleared", 1'b0, irq_o);
    @(posedge clk_i);
    deep_sleep_i <= 1'b1;
    xfer(ADR_COUNT, 1'b0, 32'h0);
    a = rd;
    repeat (40) @(posedge clk_i);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk("sleep holds", a, rd);
    xfer(ADR_MODE, 1'b1, 32'h11);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    a = rd;
    repeat (40) @(posedge clk_i);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk1("sleep runs", 1'b1, rd < a);
    deep_sleep_i <= 1'b0;
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY1});
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY2});
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk1("feed reload", 1'b1, rd[23:0] >= tc - 24'h1 && rd[23:0] <= tc);
    xfer(ADR_CLEAR, 1'b1, 32'hF);
    xfer(ADR_IRQEN, 1'b1, 32'h4);
    xfer(ADR_MODE, 1'b1, 32'h09);
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY1});
    xfer(ADR_STATUS, 1'b0, 32'h0);
    xfer(ADR_STATUS, 1'b0, 32'h0);
    chk("bad feed event", 32'h3, {30'h0, rd[2], rd[0]});
    chk1("bad feed irq", 1'b1, irq_o);
    do_reset();
    xfer(ADR_TC, 1'b1, 32'h100);
    xfer(ADR_WARN, 1'b1, 32'hF0);
    xfer(ADR_MODE, 1'b1, 32'h05);
    xfer(ADR_TC, 1'b1, 32'h180);
    xfer(ADR_TC, 1'b0, 32'h0);
    chk("tc protected", 32'h100, rd);
    n = 0;
    do
    begin
      xfer(ADR_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 1000);
    if (rd[1] !== 1'b1)
    begin
      error_cnt++;
      end_of_test();
    end
    chk1("warning", 1'b1, rd[1]);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk1("warn point", 1'b1, rd <= 32'hF0);
    xfer(ADR_TC, 1'b1, 32'h180);
    xfer(ADR_TC, 1'b0, 32'h0);
    chk("tc unlocked", 32'h180, rd);
    do_reset();
    xfer(ADR_TC, 1'b1, 32'h100);
    xfer(ADR_WINDOW, 1'b1, 32'h10);
    xfer(ADR_MODE, 1'b1, 32'h21);
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY1});
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY2});
    xfer(ADR_STATUS, 1'b0, 32'h0);
    chk1("early feed", 1'b1, rd[2]);
    xfer(ADR_CLEAR, 1'b1, 32'hF);
    n = 0;
    do
    begin
      xfer(ADR_COUNT, 1'b0, 32'h0);
      n++;
    end while (rd > 32'h0F && n < 1000);
    if (rd > 32'h0F)
    begin
      error_cnt++;
      end_of_test();
    end
    chk1("window open", 1'b1, rd <= 32'h0F);
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY1});
    xfer(ADR_FEED, 1'b1, {24'h0, FEED_KEY2});
    xfer(ADR_STATUS, 1'b0, 32'h0);
    chk1("window feed", 1'b0, rd[2]);
    xfer(ADR_COUNT, 1'b0, 32'h0);
    chk1("window reload", 1'b1, rd >= 32'hFE);
    do_reset();
    xfer(ADR_MODE, 1'b1, 32'h03);
    wt(1'b1, 20000);
    @(posedge clk_i);
    chk1("reset pulse", 1'b0, chip_reset_o);
    xfer(ADR_STATUS, 1'b0, 32'h0);
    chk1("reset flag", 1'b1, rd[3]);
    xfer(ADR_MODE, 1'b0, 32'h0);
    chk("mode cleared", 32'h0, rd);
    end_of_test();
  end

endmodule : windowed_watchdog_timer_tb_top
